// ===== rtl/eight_bit_timer_event_counter.sv
// register block, count sources and pin logic of the 8-bit timer pair
//
// Behaviour
// - unit 0 source: event fall, rise, clock over 1,4,16,64,256,1024
// - unit 1 source: event fall, rise, clock over 2,8,32,128,512,2048
// - in cascade only the lowest unit's clock select is used
// - count enable 1 starts; 0 clears counter and stops prescaler
// - mode bit 6: 0 clear on match, 1 free running pwm
// - cascade bit: 0 single unit, 1 joined onto the lower unit
// - request pair 01 resets, 10 sets the flip-flop; 00 and 11 ignored
// - set and reset request bits always read back as zero
// - bit 1: toggle enable in match mode, active low select in pwm
// - pin drive enable hands the pin to the timer flip-flop
// - pwm output goes inactive whenever count enable is cleared
// - on match: clear to zero, keep counting, interrupt, optional toggle
// - event mode counts each selected pin edge, clearing on match
// - square wave toggles on each match, start level from requests
// - pwm active from overflow until compare match, idle until start
// - clearing the lowest unit's enable clears the whole cascade
`timescale 1ns/1ps
module eight_bit_timer_event_counter
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic            i_core_clk,
  input  wire logic            i_resetn,
  // memory access port
  input  wire logic [15:0]     i_bus_addr,
  input  wire logic            i_bus_write,
  input  wire logic            i_bus_read,
  input  wire logic [7:0]      i_bus_wdata,
  output logic      [7:0]      o_bus_rdata,
  // compare values and counter status
  input  wire logic [1:0][7:0] i_compare_value,
  output logic      [1:0][7:0] o_counter_value,
  output logic      [1:0]      o_match_interrupt,
  // port 7 direction and latches of the two timer pins
  output logic      [7:0]      o_port7_direction,
  input  wire logic [1:0]      i_port_latch,
  // shared event input / timer output pins
  input  wire logic [1:0]      i_timer_pin,
  output logic      [1:0]      o_timer_pin,
  output logic      [1:0]      o_timer_pin_oe
);

  // =========================================================
  // register state
  logic [7:0]          mode_reg [UNIT_COUNT];
  logic [7:0]          mode_next [UNIT_COUNT];
  logic [2:0]          clksel_reg [UNIT_COUNT];
  logic [2:0]          clksel_next [UNIT_COUNT];
  logic [DIR_BITS-1:0] dir_reg, dir_next;
  logic [7:0]          rdata_reg, rdata_next;

  // per-unit working signals
  logic [PRESCALE_BITS-1:0] prescale_reg [UNIT_COUNT];
  logic [PRESCALE_BITS-1:0] prescale_next [UNIT_COUNT];
  logic [1:0] irq_reg, irq_next;
  logic [1:0] pin_reg, pin_next;
  logic [1:0] enable_w, pwm_w, drive_w, edge_w, src_tick_w;
  logic [1:0] tick_w, match_w, equal_w, at_top_w, flop_w;
  logic       cascade_w, match16_w;

  unit_if u_if [UNIT_COUNT] ();

  // =========================================================
  // cascade joining
  assign cascade_w = mode_reg[1][BIT_CASCADE];
  assign match16_w = equal_w[0] & equal_w[1];
  // unit 1 follows unit 0's enable when joined
  assign enable_w[0] = mode_reg[0][BIT_COUNT_ENABLE];
  assign enable_w[1] = cascade_w ? mode_reg[0][BIT_COUNT_ENABLE]
                                 : mode_reg[1][BIT_COUNT_ENABLE];
  assign tick_w[0]   = src_tick_w[0];
  // upper unit steps on the lower unit's carry or full match only
  assign tick_w[1]   = cascade_w
                       ? (src_tick_w[0] & (at_top_w[0] | match16_w))
                       : src_tick_w[1];
  assign match_w[0]  = cascade_w ? match16_w : equal_w[0];
  assign match_w[1]  = cascade_w ? match16_w : equal_w[1];

  // =========================================================
  // per-unit count source, edge detector and counter
  for (genvar g = 0; g < UNIT_COUNT; g++)
  begin : g_unit
    localparam logic [15:0] MODE_ADDR = (g == 0) ? ADDR_MODE0 : ADDR_MODE1;
    localparam logic        UNIT_ODD  = (g == 1);
    logic mode_write;

    assign mode_write = i_bus_write && (i_bus_addr == MODE_ADDR);
    assign pwm_w[g]   = mode_reg[g][BIT_PWM_MODE];
    assign drive_w[g] = mode_reg[g][BIT_PIN_DRIVE];

    event_edge u_edge (
      .i_core_clk        (i_core_clk),
      .i_resetn          (i_resetn),
      .i_enable          (enable_w[g]),
      .i_select_rising   (clksel_reg[g] == SEL_EVENT_RISE),
      .i_event_input_pin (i_timer_pin[g]),
      .o_edge_pulse      (edge_w[g])
    );

    // pin edges for codes 0 and 1, prescaler taps otherwise
    assign src_tick_w[g] = (clksel_reg[g] < SEL_FIRST_DIV)
      ? edge_w[g]
      : (enable_w[g] & tick_from_prescaler(prescale_reg[g],
           div_exponent(clksel_reg[g], UNIT_ODD)));

    assign u_if[g].enable             = enable_w[g];
    assign u_if[g].pwm_mode           = pwm_w[g];
    assign u_if[g].toggle_or_polarity = mode_reg[g][BIT_TOGGLE_POL];
    // pattern 11 is prohibited and drives neither request
    assign u_if[g].flop_set_request   = mode_write &
      i_bus_wdata[BIT_FLOP_SET] & ~i_bus_wdata[BIT_FLOP_RESET];
    assign u_if[g].flop_reset_request = mode_write &
      ~i_bus_wdata[BIT_FLOP_SET] & i_bus_wdata[BIT_FLOP_RESET];
    assign u_if[g].tick               = tick_w[g];
    assign u_if[g].match              = match_w[g];
    assign u_if[g].compare_value      = i_compare_value[g];
    assign equal_w[g]                 = u_if[g].equal;
    assign at_top_w[g]                = u_if[g].at_top;
    assign flop_w[g]                  = u_if[g].flop_out;
    assign o_counter_value[g]         = u_if[g].counter_value;

    timer_unit u_unit (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .ctl        (u_if[g])
    );
  end

  // =========================================================
  // register writes and read data
  always_comb
  begin
    mode_next   = mode_reg;
    clksel_next = clksel_reg;
    dir_next    = dir_reg;
    rdata_next  = 8'h00;
    if (i_bus_write)
    begin
      case (i_bus_addr)
        ADDR_PORT7_DIR: dir_next = i_bus_wdata[DIR_BITS-1:0];
        // request bits are not stored, so they read back as zero
        ADDR_MODE0:     mode_next[0] = i_bus_wdata & MODE_STORED_MASK;
        ADDR_MODE1:     mode_next[1] = i_bus_wdata & MODE_STORED_MASK;
        // upper select bits are dropped; software keeps them zero
        ADDR_CLKSEL0:   clksel_next[0] = i_bus_wdata[2:0];
        ADDR_CLKSEL1:   clksel_next[1] = i_bus_wdata[2:0];
        default:        ;
      endcase
    end
    if (i_bus_read)
    begin
      case (i_bus_addr)
        ADDR_PORT7_DIR: rdata_next = PORT7_FIXED_ONES | {2'b00, dir_reg};
        ADDR_MODE0:     rdata_next = mode_reg[0];
        ADDR_MODE1:     rdata_next = mode_reg[1];
        ADDR_CLKSEL0:   rdata_next = {5'h00, clksel_reg[0]};
        ADDR_CLKSEL1:   rdata_next = {5'h00, clksel_reg[1]};
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      mode_reg   <= '{default: RESET_MODE};
      clksel_reg <= '{default: RESET_CLKSEL};
      dir_reg    <= RESET_PORT7_DIR;
      rdata_reg  <= 8'h00;
    end
    else
    begin
      mode_reg   <= mode_next;
      clksel_reg <= clksel_next;
      dir_reg    <= dir_next;
      rdata_reg  <= rdata_next;
    end
  end

  // =========================================================
  // prescalers, match interrupts and pin drivers
  always_comb
  begin
    for (int n = 0; n < UNIT_COUNT; n++)
    begin
      // a stopped unit holds its prescaler at zero for an aligned start
      prescale_next[n] = enable_w[n]
        ? prescale_reg[n] + 11'h001 : '0;
      irq_next[n] = enable_w[n] & tick_w[n] & match_w[n]
                    & ~pwm_w[n];
      pin_next[n] = drive_w[n] ? flop_w[n] : i_port_latch[n];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      prescale_reg <= '{default: '0};
      irq_reg      <= 2'h0;
      pin_reg      <= 2'h0;
    end
    else
    begin
      prescale_reg <= prescale_next;
      irq_reg      <= irq_next;
      pin_reg      <= pin_next;
    end
  end

  // outputs
  assign o_bus_rdata       = rdata_reg;
  assign o_match_interrupt = irq_reg;
  assign o_port7_direction = PORT7_FIXED_ONES | {2'b00, dir_reg};
  assign o_timer_pin       = pin_reg;
  // direction bit 0 turns the buffer on
  assign o_timer_pin_oe    = ~dir_reg[PIN_FIRST +: 2];

  // =========================================================
  // checks
  property p_request_read_zero;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (i_bus_read && (i_bus_addr == ADDR_MODE0 || i_bus_addr == ADDR_MODE1))
      |=> (o_bus_rdata[BIT_FLOP_SET] == 1'b0 &&
           o_bus_rdata[BIT_FLOP_RESET] == 1'b0);
  endproperty
  a_request_read_zero: assert property (p_request_read_zero)
    else $error("flip-flop request bits read back nonzero");

  property p_cascade_stop;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (cascade_w && !mode_reg[0][BIT_COUNT_ENABLE])
      |=> (o_counter_value[0] == COUNT_ZERO &&
           o_counter_value[1] == COUNT_ZERO);
  endproperty
  a_cascade_stop: assert property (p_cascade_stop)
    else $error("cascade count not cleared by lowest enable");

  property p_cascade_source;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (cascade_w && !at_top_w[0] && !match16_w) |-> !tick_w[1];
  endproperty
  a_cascade_source: assert property (p_cascade_source)
    else $error("upper unit stepped on its own source in cascade");

  property p_div_one;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (enable_w[0] && clksel_reg[0] == SEL_FIRST_DIV) |-> src_tick_w[0];
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("unit 0 divide by one missed a tick");

  property p_div_two;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (enable_w[1] && clksel_reg[1] == SEL_FIRST_DIV && src_tick_w[1])
      |=> (!src_tick_w[1] || !enable_w[1] || !$stable(clksel_reg[1]));
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("unit 1 divide by two ticked twice in a row");

  property p_pin_drive;
    @(posedge i_core_clk) disable iff (!i_resetn)
    drive_w[0] |=> (o_timer_pin[0] == $past(flop_w[0]));
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("timer pin not driven by output flip-flop");

  property p_match_irq;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (enable_w[0] && tick_w[0] && match_w[0] && !pwm_w[0])
      |=> (o_match_interrupt[0] && o_counter_value[0] == COUNT_ZERO);
  endproperty
  a_match_irq: assert property (p_match_irq)
    else $error("match did not raise interrupt and clear counter");

  // a reset request outside pwm shows on the flip-flop one edge later
  property p_reset_request;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (i_bus_write && i_bus_addr == ADDR_MODE0 &&
     !i_bus_wdata[BIT_FLOP_SET] && i_bus_wdata[BIT_FLOP_RESET] &&
     !i_bus_wdata[BIT_PWM_MODE]) |=> !flop_w[0];
  endproperty
  a_reset_request: assert property (p_reset_request)
    else $error("reset request did not clear output flip-flop");

  property p_pwm_quiet;
    @(posedge i_core_clk) disable iff (!i_resetn)
    pwm_w[0] |=> !o_match_interrupt[0];
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet)
    else $error("match interrupt raised in pwm mode");

  // a 16-bit match pulses both interrupts; software masks the upper one
  property p_cascade_irq;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (cascade_w && enable_w[0] && tick_w[0] && match16_w &&
     !pwm_w[0] && !pwm_w[1]) |=> (o_match_interrupt == 2'h3);
  endproperty
  a_cascade_irq: assert property (p_cascade_irq)
    else $error("cascade match did not pulse both interrupts");
endmodule : eight_bit_timer_event_counter

// ===== shared/timer_pkg.sv
// constants, register map and helper functions of the 8-bit timer pair
package timer_pkg;

  // ===========================================================
  // register map
  localparam logic [15:0] ADDR_PORT7_DIR = 16'hFF27;
  localparam logic [15:0] ADDR_MODE0     = 16'hFF70;
  localparam logic [15:0] ADDR_CLKSEL0   = 16'hFF71;
  localparam logic [15:0] ADDR_MODE1     = 16'hFF78;
  localparam logic [15:0] ADDR_CLKSEL1   = 16'hFF79;

  // ===========================================================
  // reset values and fixed bits
  localparam logic [5:0] RESET_PORT7_DIR  = 6'h3F;
  localparam logic [7:0] PORT7_FIXED_ONES = 8'hC0;
  localparam logic [7:0] RESET_MODE       = 8'h00;
  localparam logic [2:0] RESET_CLKSEL     = 3'h0;
  localparam logic [7:0] MODE_STORED_MASK = 8'hD3;
  localparam int         DIR_BITS         = 6;

  // ===========================================================
  // mode control field positions
  localparam int BIT_COUNT_ENABLE = 7;
  localparam int BIT_PWM_MODE     = 6;
  localparam int BIT_CASCADE      = 4;
  localparam int BIT_FLOP_SET     = 3;
  localparam int BIT_FLOP_RESET   = 2;
  localparam int BIT_TOGGLE_POL   = 1;
  localparam int BIT_PIN_DRIVE    = 0;

  // ===========================================================
  // count source codes, counter limits, pin positions
  localparam logic [2:0] SEL_EVENT_FALL = 3'h0;
  localparam logic [2:0] SEL_EVENT_RISE = 3'h1;
  localparam logic [2:0] SEL_FIRST_DIV  = 3'h2;
  localparam int         PRESCALE_BITS  = 11;
  localparam int         UNIT_COUNT     = 2;
  localparam int         PIN_FIRST      = 2;
  localparam logic [7:0] COUNT_ZERO     = 8'h00;
  localparam logic [7:0] COUNT_MAX      = 8'hFF;

  // divider exponent: even powers for unit 0, odd powers for unit 1
  function automatic logic [3:0] div_exponent(input logic [2:0] sel,
                                              input logic       unit_odd);
    logic [2:0] step;
    step = 3'(sel - SEL_FIRST_DIV);
    div_exponent = {step, unit_odd};
  endfunction : div_exponent

  // one tick every 2^exp cycles: low exp prescaler bits all ones
  function automatic logic tick_from_prescaler(
    input logic [PRESCALE_BITS-1:0] prescale,
    input logic [3:0]               exp);
    logic [PRESCALE_BITS:0] mask;
    mask = (12'h001 << exp) - 12'h001;
    tick_from_prescaler = (({1'b0, prescale} & mask) == mask);
  endfunction : tick_from_prescaler

endpackage : timer_pkg

// ===== shared/unit_if.sv
// control and status bundle between the register block and one counter unit
`timescale 1ns/1ps
interface unit_if;
  logic       enable;
  logic       pwm_mode;
  logic       toggle_or_polarity;
  logic       flop_set_request;
  logic       flop_reset_request;
  logic       tick;
  logic       match;
  logic [7:0] compare_value;
  logic [7:0] counter_value;
  logic       equal;
  logic       at_top;
  logic       flop_out;

  modport ctrl (
    output enable, pwm_mode, toggle_or_polarity, flop_set_request,
           flop_reset_request, tick, match, compare_value,
    input  counter_value, equal, at_top, flop_out
  );
  modport unit (
    input  enable, pwm_mode, toggle_or_polarity, flop_set_request,
           flop_reset_request, tick, match, compare_value,
    output counter_value, equal, at_top, flop_out
  );
endinterface : unit_if

// ===== rtl/event_edge.sv
// event pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module event_edge
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  // control
  input  wire logic i_enable,
  input  wire logic i_select_rising,
  // pin and result
  input  wire logic i_event_input_pin,
  output logic      o_edge_pulse
);
  logic sync1_reg, sync2_reg, last_reg, pulse_reg;
  logic pulse_next;

  // =========================================================
  // edge select; last level tracks always so a restart sees no false edge
  always_comb
  begin
    if (i_select_rising)
      pulse_next = i_enable & sync2_reg & ~last_reg;
    else
      pulse_next = i_enable & ~sync2_reg & last_reg;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= i_event_input_pin;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
      pulse_reg <= pulse_next;
    end
  end

  assign o_edge_pulse = pulse_reg;
endmodule : event_edge

// ===== rtl/timer_unit.sv
// one 8-bit counter with compare clear, pwm level and output flip-flop
`timescale 1ns/1ps
module timer_unit
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  // control and status bundle
  unit_if.unit      ctl
);
  logic [7:0] count_reg, count_next;
  logic       flop_reg, flop_next;
  logic       pwm_active_reg, pwm_active_next;

  // =========================================================
  // counter, pwm level and output flip-flop next state
  always_comb
  begin
    count_next      = count_reg;
    flop_next       = flop_reg;
    pwm_active_next = pwm_active_reg;
    if (!ctl.enable)
    begin
      count_next      = COUNT_ZERO;
      pwm_active_next = 1'b0;
    end
    else if (ctl.tick)
    begin
      if (!ctl.pwm_mode && ctl.match)
        count_next = COUNT_ZERO;
      else
        count_next = count_reg + 8'h01;   // pwm wraps freely
      if (ctl.pwm_mode)
      begin
        // overflow wins, so a compare of FFH keeps the level active
        if (count_reg == COUNT_MAX)
          pwm_active_next = 1'b1;
        else if (ctl.equal)
          pwm_active_next = 1'b0;
      end
      else if (ctl.match && ctl.toggle_or_polarity)
        flop_next = ~flop_reg;
    end
    // a request written by software beats a toggle in the same cycle
    if (ctl.flop_set_request)
      flop_next = 1'b1;
    else if (ctl.flop_reset_request)
      flop_next = 1'b0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      count_reg      <= COUNT_ZERO;
      flop_reg       <= 1'b0;
      pwm_active_reg <= 1'b0;
    end
    else
    begin
      count_reg      <= count_next;
      flop_reg       <= flop_next;
      pwm_active_reg <= pwm_active_next;
    end
  end

  // status back to the register block
  assign ctl.counter_value = count_reg;
  assign ctl.equal         = (count_reg == ctl.compare_value);
  assign ctl.at_top        = (count_reg == COUNT_MAX);
  assign ctl.flop_out      = ctl.pwm_mode
                             ? (pwm_active_reg ^ ctl.toggle_or_polarity)
                             : flop_reg;

  // =========================================================
  // checks
  property p_stop_clears;
    @(posedge i_core_clk) disable iff (!i_resetn)
    !ctl.enable |=> (count_reg == COUNT_ZERO);
  endproperty
  a_stop_clears: assert property (p_stop_clears)
    else $error("counter not cleared while stopped");

  property p_step;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (ctl.enable && ctl.tick && !(ctl.match && !ctl.pwm_mode))
      |=> (count_reg == 8'($past(count_reg) + 8'h01));
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step by one on a tick");

  property p_pwm_idle;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (!ctl.enable && ctl.pwm_mode) |=> ##1
      (!ctl.pwm_mode || ctl.flop_out == ctl.toggle_or_polarity);
  endproperty
  a_pwm_idle: assert property (p_pwm_idle)
    else $error("pwm output not inactive after stop");

  property p_toggle;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (ctl.enable && ctl.tick && ctl.match && !ctl.pwm_mode &&
     ctl.toggle_or_polarity && !ctl.flop_set_request &&
     !ctl.flop_reset_request) |=> (flop_reg != $past(flop_reg));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("output flip-flop did not toggle on match");
endmodule : timer_unit

// ===== tb/pin_partner.sv
// far-side model: event source and load on the two timer pins
`timescale 1ns/1ps
module pin_partner
(
  // drive from the device
  input  wire logic [1:0] i_pin_out,
  input  wire logic [1:0] i_pin_oe,
  // event level chosen by the bench
  input  wire logic [1:0] i_source_level,
  // resolved wire level
  output logic      [1:0] o_wire_level
);
  // ==========================================================
  // pin level
  // the device owns the wire only while it drives it
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      o_wire_level[k] = i_pin_oe[k] ? i_pin_out[k] : i_source_level[k];
    end
  end
endmodule : pin_partner

// ===== tb/eight_bit_timer_event_counter_tb_top.sv
// self-checking bench of the 8-bit timer pair
`timescale 1ns/1ps
module eight_bit_timer_event_counter_tb_top
  import timer_pkg::*;
;
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;}
    row_type;
  logic            clk;
  logic            rstn;
  logic [15:0]     addr;
  logic            wr;
  logic            rd;
  logic [7:0]      wdata;
  logic [7:0]      rdata;
  logic [1:0][7:0] cmp;
  logic [1:0][7:0] cnt;
  logic [1:0]      irq;
  logic [7:0]      dir;
  logic [1:0]      pin;
  logic [1:0]      pin_out;
  logic [1:0]      pin_oe;
  logic [1:0]      src;
  logic [1:0]      latch;
  int              fail_count;
  int              checks_done;
  int              n;
  int              h;
  int              hits[2];
  logic [15:0]     mode_a[2] = '{ADDR_MODE0, ADDR_MODE1};
  logic [15:0]     sel_a[2] = '{ADDR_CLKSEL0, ADDR_CLKSEL1};
  logic [15:0]     regs[5] = '{ADDR_PORT7_DIR, ADDR_MODE0, ADDR_CLKSEL0,
                               ADDR_MODE1, ADDR_CLKSEL1};
  // unmapped address last; select upper bits and request bits drop
  row_type rows[9] = '{'{16'hFF71, 8'hFF, 8'h07}, '{16'hFF79, 8'h0A, 8'h02},
    '{16'hFF70, 8'h7F, 8'h53}, '{16'hFF70, 8'h08, 8'h00},
    '{16'hFF27, 8'h00, 8'hC0}, '{16'hFF27, 8'hFF, 8'hFF},
    '{16'hFF71, 8'h00, 8'h00}, '{16'hFF79, 8'h00, 8'h00},
    '{16'hFF00, 8'h55, 8'h00}};

  eight_bit_timer_event_counter uut
  (
    .i_core_clk        (clk),
    .i_resetn          (rstn),
    .i_bus_addr        (addr),
    .i_bus_write       (wr),
    .i_bus_read        (rd),
    .i_bus_wdata       (wdata),
    .o_bus_rdata       (rdata),
    .i_compare_value   (cmp),
    .o_counter_value   (cnt),
    .o_match_interrupt (irq),
    .o_port7_direction (dir),
    .i_port_latch      (latch),
    .i_timer_pin       (pin),
    .o_timer_pin       (pin_out),
    .o_timer_pin_oe    (pin_oe)
  );

  pin_partner partner
  (
    .i_pin_out      (pin_out),
    .i_pin_oe       (pin_oe),
    .i_source_level (src),
    .o_wire_level   (pin)
  );

  // ==========================================================
  // clock, interrupt tally, watchdog
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pulses are one cycle wide, so the bench tallies them here
  always @(posedge clk)
  begin
    if (irq[0] === 1'b1) hits[0]++;
    if (irq[1] === 1'b1) hits[1]++;
  end
  // the run needs about 10k cycles; this is well beyond that
  initial
  begin
    #200000;
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // shared tasks
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic check8(input string what, input logic [7:0] e,
                        input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check8
  task automatic checkn(input string what, input int e, input int g);
    checks_done++;
    if (g != e)
    begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", what, e, g);
    end
  endtask : checkn
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step();
    wr = 1'b0;
    // a free edge keeps two strobes from meeting in one time step
    step();
  endtask : wr_reg
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    step();
    rd = 1'b0;
    check8("rdata", e, rdata);
    step();
  endtask : rd_chk
  // cycles until the next match pulse, bounded
  task automatic wait_irq(input int u);
    n = 0;
    do
    begin
      step();
      n++;
    end
    while (irq[u] !== 1'b1 && n < 5000);
    check8("irq", 8'h01, {7'h00, irq[u]});
  endtask : wait_irq
  task automatic pulse(input int u);
    src[u] = 1'b1;
    repeat (8) step();
    src[u] = 1'b0;
    repeat (8) step();
  endtask : pulse
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // ==========================================================
  // main sequence
  initial
  begin
    {addr, wdata, cmp, src, latch, wr, rd, rstn} = '0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    check8("dir", 8'hFF, dir);
    check8("oe", 8'h00, {6'h00, pin_oe});
    for (int i = 0; i < 5; i++)
      rd_chk(regs[i], (i == 0) ? 8'hFF : 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    // every clock divider, stopping before each reselect
    for (int u = 0; u < 2; u++)
      for (int k = 2; k < 8; k++)
      begin
        wr_reg(sel_a[u], 8'(k));
        wr_reg(mode_a[u], 8'h80);
        wait_irq(u);
        wait_irq(u);
        checkn("divide", 1 << (2 * (k - 2) + u), n);
        wr_reg(mode_a[u], 8'h00);
      end
    // square wave on pin 0, start level set by request
    cmp = {8'h00, 8'h03};
    // with the timer off the pin shows the port latch
    latch = 2'b01;
    wr_reg(ADDR_PORT7_DIR, 8'hFB);
    check8("pin0 latch", 8'h01, {7'h00, pin[0]});
    latch = 2'b00;
    wr_reg(ADDR_CLKSEL0, 8'h02);
    wr_reg(ADDR_MODE0, 8'h8B);
    step();
    check8("pin0", 8'h01, {7'h00, pin[0]});
    wait_irq(0);
    check8("cnt0", 8'h00, cnt[0]);
    step();
    check8("pin0", 8'h00, {7'h00, pin[0]});
    wait_irq(0);
    checkn("period", 4, n + 1);
    repeat (2) step();
    wr_reg(ADDR_MODE0, 8'h00);
    step();
    check8("cnt0", 8'h00, cnt[0]);
    // flip-flop was left high; reset request with drive only
    wr_reg(ADDR_MODE0, 8'h05);
    check8("pin0 reset req", 8'h00, {7'h00, pin[0]});
    // event counting: unit 0 falling, unit 1 rising
    wr_reg(ADDR_PORT7_DIR, 8'hFF);
    cmp = {8'h02, 8'h02};
    for (int u = 0; u < 2; u++)
    begin
      wr_reg(sel_a[u], 8'(u));
      wr_reg(mode_a[u], 8'h80);
      pulse(u);
      pulse(u);
      check8("event cnt", 8'h02, cnt[u]);
      h = hits[u];
      pulse(u);
      check8("event cnt", 8'h00, cnt[u]);
      checkn("event irq", 1, hits[u] - h);
      wr_reg(mode_a[u], 8'h00);
    end
    // pwm on pin 0, both polarities
    wr_reg(ADDR_PORT7_DIR, 8'hFB);
    wr_reg(ADDR_CLKSEL0, 8'h02);
    cmp = {8'h00, 8'h40}; // set once, before pwm runs
    for (int p = 0; p < 2; p++)
    begin
      wr_reg(ADDR_MODE0, 8'(8'hC1 | (p << 1)));
      repeat (100) step();
      check8("pwm", 8'(p), {7'h00, pin[0]});
      repeat (190) step();
      check8("pwm", 8'(1 - p), {7'h00, pin[0]});
      repeat (60) step();
      check8("pwm", 8'(p), {7'h00, pin[0]});
      repeat (190) step();
      check8("pwm", 8'(1 - p), {7'h00, pin[0]});
      wr_reg(ADDR_MODE0, 8'(8'h41 | (p << 1)));
      repeat (2) step();
      check8("pwm stop", 8'(p), {7'h00, pin[0]});
      wr_reg(ADDR_MODE0, 8'h00);
    end
    // cascade: 16-bit compare 0100, upper select ignored
    cmp = {8'h01, 8'h00};
    wr_reg(ADDR_CLKSEL1, 8'h07);
    wr_reg(ADDR_MODE1, 8'h90);
    wr_reg(ADDR_MODE0, 8'h80);
    wait_irq(0);
    step();
    h = hits[1];
    wait_irq(0);
    checkn("cascade", 257, n + 1);
    step();
    checkn("upper irq", 1, hits[1] - h);
    repeat (100) step();
    wr_reg(ADDR_MODE0, 8'h00);
    step();
    check8("cnt both", 8'h00, cnt[0] | cnt[1]);
    // reset in mid-run: registers return to their reset values
    rstn = 1'b0;
    repeat (2) step();
    rstn = 1'b1;
    check8("dir", 8'hFF, dir);
    rd_chk(ADDR_MODE1, 8'h00);
    rd_chk(ADDR_CLKSEL1, 8'h00);
    finish_test();
  end
endmodule : eight_bit_timer_event_counter_tb_top
